// File: logic/scsp_pkg.sv
// constants and carrier types of the switch control serial port
// assumes a 50 MHz core clock; serial pins arrive asynchronously
// Function
// - sense-ready low while current sense accurate
// - release sense-ready at each turn-off instant
// - direct input low off, high on
// - rising direct input wakes from sleep
// - profile select low bulb, high motor
// - fault flag low on any fault
// - reading fault registers clears their bits
// - external pwm clock drives pwm, monitored
// - wake/reset low clears serial registers
// - sleep after input idle timeout, reset low
// - wake/reset rise starts watchdog on first bit; code arms and counts from the rise itself
// - toggle bit must alternate within timeout
// - chip select rise commits shifted word
// - chip select fall loads output shifter
// - output driver enabled only while selected
// - sample input falling, change output rising
// - sixteen bit frames, msb first
// - bits twelve to nine address register
// - output carries register or previous word
// - fail-safe flag low on communication loss
// - pwm up to 1 kHz, internal or external
// - input idle after 250 ms without activity
// - watchdog 310 ms, disabled by off bit
package scsp_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int IDLE_MS        = 250;
  localparam int WDOG_MS        = 310;
  localparam int IDLE_CYC       = IDLE_MS * (CLK_HZ / 1000);
  localparam int WDOG_CYC       = WDOG_MS * (CLK_HZ / 1000);
  localparam int PWM_MAX_HZ     = 1000;
  localparam int INT_PWM_CYC    = CLK_HZ / PWM_MAX_HZ;
  localparam int CLKMON_CYC     = 2 * INT_PWM_CYC;
  localparam int FRAME_BITS     = 16;
  localparam int ADDR_LSB       = 9;
  localparam int ADDR_MSB       = 12;
  localparam int WD_BIT         = 15;
  // register indexes
  localparam logic [3:0] A_CTRL0   = 4'h0;
  localparam logic [3:0] A_CTRL1   = 4'h1;
  localparam logic [3:0] A_GLOBAL  = 4'h2;
  localparam logic [3:0] A_STATUS  = 4'h3;
  localparam logic [3:0] A_FAULT0  = 4'h4;
  localparam logic [3:0] A_FAULT1  = 4'h5;
  localparam logic [3:0] A_DIAG0   = 4'h6;
  localparam logic [3:0] A_DIAG1   = 4'h7;
  localparam logic [3:0] A_ECHO    = 4'hf;
  // control register fields: [7:0] duty, 8 on, ... global: 0 wd off, 1 ext clk sel, 2 pwm en
  localparam int F_ON           = 8;
  localparam int G_WDOFF        = 0;
  localparam int G_EXTCLK       = 1;
  localparam int G_PWMEN        = 2;
  localparam int G_DIRDIS       = 3;
  localparam logic [15:0] REG_RST = 16'h0000;
  // fault bit layout per channel
  typedef struct packed {
    logic oc;
    logic ot;
    logic short_vpwr;
    logic severe_sc;
    logic open_load_on_state;
    logic open_load_off_state;
  } scsp_chfault_t;
  typedef struct packed {
    logic ov;
    logic uv;
    logic clk_fail;
  } scsp_glfault_t;
  typedef enum logic [1:0] {
    SCSP_SLEEP  = 2'b00,
    SCSP_NORMAL = 2'b01,
    SCSP_FSAFE  = 2'b11
  } scsp_mode_t;
endpackage

// File: logic/scsp_fifo.sv
// small flop fifo carrying committed serial words
// assumes both sides on one clock
`timescale 1ns/10ps
module scsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW:0]   wp;
  logic [AW:0]   rp;
  logic          full;
  logic          empty;
  assign full        = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty       = (wp == rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rp[AW-1:0]];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// File: logic/scsp_top.sv
// digital control of a dual high-side switch: serial port, direct inputs, watchdog, pwm
// assumes all pins asynchronous to clk_i; serial clock well below clk_i/4
`timescale 1ns/10ps
module scsp_top import scsp_pkg::*; #(
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int WDOG_CYCLES = WDOG_CYC,
  parameter int CLKMON_CYCLES = CLKMON_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          chip_select_n_i,
  input  wire logic          sclk_i,
  input  wire logic          sdi_i,
  output logic               sdo_o,
  output logic               sdo_oe_o,
  input  wire logic [1:0]    direct_in_i,
  input  wire logic [1:0]    load_profile_sel_i,
  input  wire logic          wake_reset_n_i,
  input  wire logic          pwm_clk_i,
  input  wire logic          sense_accurate_i,
  input  wire scsp_chfault_t fault_a_i,
  input  wire scsp_chfault_t fault_b_i,
  input  wire logic          ov_i,
  input  wire logic          uv_i,
  input  wire logic          vdd_fail_i,
  output logic               output_switch_a_o,
  output logic               output_switch_b_o,
  output logic [1:0]         motor_profile_o,
  output logic               fault_flag_n_o,
  output logic               fault_flag_n_oe_o,
  output logic               failsafe_flag_n_o,
  output logic               failsafe_flag_n_oe_o,
  output logic               sense_ready_n_o,
  output logic               sense_ready_n_oe_o,
  output logic               awake_o,
  output logic [15:0]        word_data_o,
  output logic               word_valid_o,
  input  wire logic          word_ready_i
);
  typedef struct packed {
    logic [1:0]  s1;
    logic [1:0]  s2;
  } pair_t;
  typedef struct packed {
    logic [6:0]  m1;
    logic [6:0]  m2;
    logic        sclk_d;
    logic        csn_d;
    logic        pwm_d;
    logic [1:0]  din_d;
    logic        wrn_d;
    logic [15:0] shin;
    logic [15:0] shout;
    logic [15:0] prev_word;
    logic [4:0]  nbits;
    logic [15:0] ctrl0;
    logic [15:0] ctrl1;
    logic [15:0] glob;
    scsp_chfault_t flt0;
    scsp_chfault_t flt1;
    scsp_glfault_t gfl;
    logic        wd_armed;
    logic        wd_last;
    logic [31:0] wd_cnt;
    logic [31:0] idle0;
    logic [31:0] idle1;
    logic [1:0]  in_on;
    scsp_mode_t  mode;
    logic [31:0] mon_cnt;
    logic [31:0] ipwm_cnt;
    logic [7:0]  pwm_phase;
    logic [1:0]  hson;
    logic        sdo;
    logic        sdo_oe;
    logic        fault_n;
    logic        fs_n;
    logic        sync_n;
    logic [1:0]  prof;
    logic        push;
    logic [15:0] push_data;
    logic        awake;
  } st_t;
  st_t st;
  st_t next_st;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;

  function automatic logic [15:0] rd_reg(input st_t s, input logic [3:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      A_CTRL0:  v = s.ctrl0;
      A_CTRL1:  v = s.ctrl1;
      A_GLOBAL: v = s.glob;
      A_STATUS: v = {9'h000, s.mode, s.gfl, s.hson};
      A_FAULT0: v = {10'h000, s.flt0};
      A_FAULT1: v = {10'h000, s.flt1};
      A_DIAG0:  v = {14'h0000, s.prof[0], s.in_on[0]};
      A_DIAG1:  v = {14'h0000, s.prof[1], s.in_on[1]};
      default:  v = s.prev_word;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] sat_inc(input logic [31:0] c, input int lim);
    return (c >= 32'(lim)) ? c : c + 32'd1;
  endfunction

  always_comb begin
    logic sclk;
    logic csn;
    logic sdi;
    logic pwm;
    logic [1:0] din;
    logic wrn;
    logic [3:0] addr;
    logic [15:0] w;
    logic clk_ok;
    logic pwm_tick;
    logic [1:0] duty_on;
    logic any_fault;
    sclk = st.m2[0];
    csn  = st.m2[1];
    sdi  = st.m2[2];
    pwm  = st.m2[3];
    din  = st.m2[5:4];
    wrn  = st.m2[6];
    addr = 4'h0;
    w    = 16'h0000;
    clk_ok    = 1'b0;
    pwm_tick  = 1'b0;
    duty_on   = 2'b00;
    any_fault = 1'b0;
    next_st = st;
    next_st.m1 = {wake_reset_n_i, direct_in_i, pwm_clk_i, sdi_i, chip_select_n_i, sclk_i};
    next_st.m2 = st.m1;
    next_st.sclk_d = sclk;
    next_st.csn_d = csn;
    next_st.pwm_d = pwm;
    next_st.din_d = din;
    next_st.wrn_d = wrn;
    next_st.push = 1'b0;
    // hardware sets fault bits; merged last so set wins over read clear
    if (csn && !st.csn_d) begin
      w = st.shin;
      addr = w[ADDR_MSB:ADDR_LSB];
      if (st.nbits == 5'(FRAME_BITS)) begin
        next_st.prev_word = w;
        next_st.push = 1'b1;
        next_st.push_data = w;
        unique case (addr)
          A_CTRL0:  next_st.ctrl0 = w;
          A_CTRL1:  next_st.ctrl1 = w;
          A_GLOBAL: next_st.glob = w;
          default: ;
        endcase
        if (st.wd_armed && (w[WD_BIT] != st.wd_last)) begin
          next_st.wd_cnt = 32'd0;
        end
        next_st.wd_last = w[WD_BIT];
      end
    end
    if (!csn && st.csn_d) begin
      addr = st.shin[ADDR_MSB:ADDR_LSB];
      next_st.shout = rd_reg(st, addr);
      next_st.sdo = next_st.shout[FRAME_BITS-1];
      next_st.nbits = 5'd0;
      unique case (addr)
        A_STATUS: next_st.gfl = '0;
        A_FAULT0: next_st.flt0 = '0;
        A_FAULT1: next_st.flt1 = '0;
        default: ;
      endcase
    end
    if (!csn) begin
      if (!sclk && st.sclk_d) begin
        next_st.shin = {st.shin[14:0], sdi};
        if (st.nbits != 5'd31) begin
          next_st.nbits = st.nbits + 5'd1;
        end
      end
      // each rise presents the current msb, so the first rise shows bit 15
      if (sclk && !st.sclk_d) begin
        next_st.shout = {st.shout[14:0], 1'b0};
        next_st.sdo = st.shout[15];
      end
    end
    next_st.sdo_oe = !csn;
    if (!wrn) begin
      next_st.ctrl0 = REG_RST;
      next_st.ctrl1 = REG_RST;
      next_st.glob = REG_RST;
      next_st.wd_armed = 1'b0;
      next_st.wd_cnt = 32'd0;
    end else if (!st.wrn_d) begin
      next_st.wd_armed = 1'b1;
      next_st.wd_cnt = 32'd0;
    end else if (st.wd_armed && !st.glob[G_WDOFF]) begin
      next_st.wd_cnt = sat_inc(next_st.wd_cnt, WDOG_CYCLES);
    end
    for (int i = 0; i < 2; i++) begin
      if (din[i] != st.din_d[i] || din[i]) begin
        if (i == 0) next_st.idle0 = 32'd0;
        else next_st.idle1 = 32'd0;
        next_st.in_on[i] = 1'b1;
      end else begin
        if (i == 0) next_st.idle0 = sat_inc(st.idle0, IDLE_CYCLES);
        else next_st.idle1 = sat_inc(st.idle1, IDLE_CYCLES);
        if ((i == 0 ? st.idle0 : st.idle1) >= 32'(IDLE_CYCLES)) next_st.in_on[i] = 1'b0;
      end
    end
    // mode sequencing
    unique case (st.mode)
      SCSP_SLEEP: begin
        if ((din & ~st.din_d) != 2'b00 || (wrn && !st.wrn_d)) begin
          next_st.mode = SCSP_NORMAL;
        end
      end
      SCSP_NORMAL: begin
        if (!wrn && st.in_on == 2'b00 && din == 2'b00) begin
          next_st.mode = SCSP_SLEEP;
        end else if ((st.wd_armed && !st.glob[G_WDOFF] && st.wd_cnt >= 32'(WDOG_CYCLES)) || vdd_fail_i) begin
          next_st.mode = SCSP_FSAFE;
        end
      end
      SCSP_FSAFE: begin
        if (!wrn && st.in_on == 2'b00 && din == 2'b00) begin
          next_st.mode = SCSP_SLEEP;
        end else if (wrn && !st.wrn_d) begin
          next_st.mode = SCSP_NORMAL;
        end
      end
      default: next_st.mode = SCSP_SLEEP;
    endcase
    // external clock monitor and pwm time base
    clk_ok = st.mon_cnt < 32'(CLKMON_CYCLES);
    if (pwm != st.pwm_d) next_st.mon_cnt = 32'd0;
    else next_st.mon_cnt = sat_inc(st.mon_cnt, CLKMON_CYCLES);
    next_st.ipwm_cnt = (st.ipwm_cnt >= 32'(INT_PWM_CYC / 256 - 1)) ? 32'd0 : st.ipwm_cnt + 32'd1;
    if (st.glob[G_EXTCLK]) pwm_tick = pwm && !st.pwm_d && clk_ok;
    else pwm_tick = (st.ipwm_cnt == 32'd0);
    if (pwm_tick) next_st.pwm_phase = st.pwm_phase + 8'd1;
    duty_on[0] = st.pwm_phase < st.ctrl0[7:0];
    duty_on[1] = st.pwm_phase < st.ctrl1[7:0];
    for (int i = 0; i < 2; i++) begin
      logic on_bit;
      on_bit = (i == 0) ? st.ctrl0[F_ON] : st.ctrl1[F_ON];
      if (st.mode == SCSP_SLEEP) next_st.hson[i] = 1'b0;
      else if (!wrn || st.mode == SCSP_FSAFE) next_st.hson[i] = din[i];
      else next_st.hson[i] = (din[i] && !st.glob[G_DIRDIS]) ||
                             (on_bit && (!st.glob[G_PWMEN] || duty_on[i]));
    end
    // fault capture, set over clear
    next_st.flt0 = next_st.flt0 | fault_a_i;
    next_st.flt1 = next_st.flt1 | fault_b_i;
    next_st.gfl.ov = next_st.gfl.ov | ov_i;
    next_st.gfl.uv = next_st.gfl.uv | uv_i;
    next_st.gfl.clk_fail = next_st.gfl.clk_fail | (st.glob[G_EXTCLK] && !clk_ok);
    any_fault = (|next_st.flt0) || (|next_st.flt1) || (|next_st.gfl);
    next_st.fault_n = !any_fault;
    next_st.fs_n = !(next_st.mode == SCSP_FSAFE || vdd_fail_i);
    if ((st.hson & ~next_st.hson) != 2'b00) next_st.sync_n = 1'b1;
    else if (sense_accurate_i && next_st.hson != 2'b00) next_st.sync_n = 1'b0;
    next_st.prof = load_profile_sel_i;
    next_st.awake = next_st.mode != SCSP_SLEEP;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.csn_d <= 1'b1;
      st.wrn_d <= 1'b0;
      // idle levels: select high, serial clock low, so no false edge after reset
      st.m1 <= 7'h02;
      st.m2 <= 7'h02;
      st.fault_n <= 1'b1;
      st.fs_n <= 1'b1;
      st.sync_n <= 1'b1;
      st.prof <= 2'b11;
      st.mode <= SCSP_SLEEP;
    end else begin
      st <= next_st;
    end
  end

  scsp_fifo #(
    .W (16),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (st.push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (st.push_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (word_ready_i && !st.push),
    .out_data_o  (fifo_out_data)
  );

  logic [15:0] wd_q;
  logic        wv_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_q <= 16'h0000;
      wv_q <= 1'b0;
    end else begin
      wv_q <= fifo_out_valid && word_ready_i && !st.push;
      wd_q <= fifo_out_data;
    end
  end

  assign sdo_o                = st.sdo;
  assign sdo_oe_o             = st.sdo_oe;
  assign output_switch_a_o    = st.hson[0];
  assign output_switch_b_o    = st.hson[1];
  assign motor_profile_o      = st.prof;
  assign fault_flag_n_o       = 1'b0;
  assign fault_flag_n_oe_o    = !st.fault_n;
  assign failsafe_flag_n_o    = 1'b0;
  assign failsafe_flag_n_oe_o = !st.fs_n;
  assign sense_ready_n_o      = 1'b0;
  assign sense_ready_n_oe_o   = !st.sync_n;
  assign awake_o              = st.awake;
  assign word_data_o          = wd_q;
  assign word_valid_o         = wv_q;
  logic unused_ready;
  assign unused_ready = fifo_in_ready;
endmodule

// File: verification/scsp_checker.sv
// assertions on the pins of the switch control serial port
// assumes binding into scsp_top, one core clock domain
`timescale 1ns/10ps
module scsp_checker import scsp_pkg::*; (
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          chip_select_n_i,
  input wire logic          sdo_oe_o,
  input wire logic [1:0]    direct_in_i,
  input wire logic [1:0]    load_profile_sel_i,
  input wire logic          wake_reset_n_i,
  input wire scsp_chfault_t fault_a_i,
  input wire logic          ov_i,
  input wire logic          uv_i,
  input wire logic          vdd_fail_i,
  input wire logic          output_switch_a_o,
  input wire logic [1:0]    motor_profile_o,
  input wire logic          fault_flag_n_oe_o,
  input wire logic          failsafe_flag_n_oe_o,
  input wire logic          sense_ready_n_oe_o,
  input wire logic          awake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence idle_s; chip_select_n_i [*5]; endsequence
  sequence sel_s; (!chip_select_n_i && !vdd_fail_i) [*5]; endsequence
  sequence dir_off_s; (!wake_reset_n_i && !direct_in_i[0]) [*6]; endsequence
  sequence dir_on_s; $rose(direct_in_i[0]) && !wake_reset_n_i; endsequence
  oe_off_a: assert property (idle_s |-> !sdo_oe_o)
    else $error("sdo driven while deselected");
  oe_on_a: assert property (sel_s |-> sdo_oe_o)
    else $error("sdo not driven while selected");
  dir_off_a: assert property (dir_off_s |-> !output_switch_a_o)
    else $error("channel on with direct input low");
  dir_on_a: assert property (dir_on_s |-> ##[2:8] output_switch_a_o)
    else $error("channel not on after direct rise");
  profile_a: assert property ($stable(load_profile_sel_i) [*5] |-> motor_profile_o == load_profile_sel_i)
    else $error("profile does not follow select");
  wake_a: assert property ($rose(wake_reset_n_i) |-> ##[1:6] awake_o)
    else $error("no wake after wake input rise");
  fault_oc_a: assert property (fault_a_i.oc [*4] |-> fault_flag_n_oe_o)
    else $error("fault flag not pulled on overcurrent");
  fault_sup_a: assert property ((ov_i || uv_i) [*4] |-> fault_flag_n_oe_o)
    else $error("fault flag not pulled on supply fault");
  failsafe_vdd_a: assert property (vdd_fail_i [*4] |-> failsafe_flag_n_oe_o)
    else $error("fail-safe flag not pulled on supply loss");
  sense_off_a: assert property ($fell(output_switch_a_o) |-> ##[0:4] !sense_ready_n_oe_o)
    else $error("sense ready not released at turn-off");
endmodule
bind scsp_top scsp_checker u_chk (.*);

// File: verification/scsp_host.sv
// serial port host model: select, serial clock and data out
// assumes core clock clk_i; every change at its falling edge
`timescale 1ns/10ps
module scsp_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // sclk 160 ns period, stands low outside frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    wait_n(1);
    cs_n_o = 1'b0;
    wait_n(25);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = tx[i];
      wait_n(1);
      sclk_o = 1'b1;
      wait_n(4);
      sclk_o = 1'b0;
      wait_n(3);
      // read late in the low phase; undriven sdo gives unknown
      rx[i] = sdo_oe_i ? sdo_i : 1'bx;
    end
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o;
    wait_n(50);
  endtask
endmodule

// File: verification/tb_scsp_top.sv
// self-checking bench for scsp_top with a serial host model
// assumes shortened idle, watchdog and clock monitor counts
`timescale 1ns/10ps
module tb_scsp_top import scsp_pkg::*; ;
  localparam int IDLE = 2000;
  localparam int WDOG = 3000;
  localparam int CMON = 100;
  localparam int FD   = 16;
  logic clk_i, rst_n_i, chip_select_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, wake_reset_n_i;
  logic pwm_clk_i, sense_accurate_i, ov_i, uv_i, vdd_fail_i, word_valid_o, word_ready_i;
  logic output_switch_a_o, output_switch_b_o, awake_o, sense_ready_n_o, sense_ready_n_oe_o;
  logic fault_flag_n_o, fault_flag_n_oe_o, failsafe_flag_n_o, failsafe_flag_n_oe_o;
  logic [1:0]    direct_in_i, load_profile_sel_i, motor_profile_o;
  logic [15:0]   word_data_o, rx;
  scsp_chfault_t fault_a_i, fault_b_i;
  logic          wd_bit = 1'b0;
  logic [15:0]   sent[$];
  int            n_mismatch = 0;
  int            n_checks = 0;
  scsp_top #(.IDLE_CYCLES(IDLE), .WDOG_CYCLES(WDOG), .CLKMON_CYCLES(CMON), .FIFO_DEPTH(FD)) u_dut (.*);
  scsp_host u_host (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .cs_n_o(chip_select_n_i),
                    .sclk_o(sclk_i), .sdi_o(sdi_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // toggle bit alternates on every frame
  task automatic send(input logic [3:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {wd_bit, 2'b00, a, d};
    wd_bit = ~wd_bit;
    sent.push_back(w);
    u_host.xfer(w, rx);
  endtask
  task automatic t_reset();
    check("sdo_oe", sdo_oe_o, 1'b0);
    check("switch_a", output_switch_a_o, 1'b0);
    for (int p = 0; p < 4; p++) begin
      load_profile_sel_i = p[1:0];
      cyc(6);
      check("profile", motor_profile_o, p[1:0]);
    end
  endtask
  task automatic t_direct();
    direct_in_i = 2'b01;
    cyc(8);
    check("awake", awake_o, 1'b1);
    check("switch_a", output_switch_a_o, 1'b1);
    check("switch_b", output_switch_b_o, 1'b0);
    sense_accurate_i = 1'b1;
    cyc(8);
    check("sense", sense_ready_n_oe_o, 1'b1);
    direct_in_i = 2'b10;
    cyc(8);
    check("switch_a", output_switch_a_o, 1'b0);
    check("switch_b", output_switch_b_o, 1'b1);
    sense_accurate_i = 1'b0;
    direct_in_i = 2'b00;
    cyc(IDLE - 100);
    check("awake", awake_o, 1'b1);
    cyc(200);
    check("awake", awake_o, 1'b0);
  endtask
  task automatic t_spi();
    wake_reset_n_i = 1'b1;
    cyc(8);
    check("awake", awake_o, 1'b1);
    send(A_CTRL0, 9'h100);
    cyc(8);
    check("switch_a", output_switch_a_o, 1'b1);
    check("switch_b", output_switch_b_o, 1'b0);
    wake_reset_n_i = 1'b0;
    cyc(8);
    check("switch_a", output_switch_a_o, 1'b0);
  endtask
  // fifo filled past depth with the reader stalled, then drained
  task automatic t_fifo();
    int n;
    wake_reset_n_i = 1'b1;
    cyc(8);
    word_ready_i = 1'b0;
    sent.delete();
    for (int i = 0; i <= FD; i++) send(A_CTRL1, i[8:0]);
    word_ready_i = 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (word_valid_o === 1'b1) begin
        if (n < FD) check("word", word_data_o, sent[n]);
        n++;
      end
    end
    check("words", n[15:0], FD[15:0]);
    send(A_ECHO, 9'h15a);
    send(A_CTRL1, 9'h000);
    check("echo", rx, sent[sent.size() - 2]);
  endtask
  task automatic t_fault();
    logic [3:0] a;
    for (int k = 0; k < 3; k++) begin
      fault_a_i.oc = (k == 0);
      ov_i = (k == 1);
      uv_i = (k == 2);
      cyc(6);
      check("fault_flag", fault_flag_n_oe_o, 1'b1);
      fault_a_i = '0;
      ov_i = 1'b0;
      uv_i = 1'b0;
      a = (k == 0) ? A_FAULT0 : A_STATUS;
      send(a, 9'h000);
      send(a, 9'h000);
      cyc(8);
      check("fault_flag", fault_flag_n_oe_o, 1'b0);
    end
    // external clock selected but standing still
    send(A_GLOBAL, 9'h006);
    cyc(3 * CMON);
    check("clk_fail", fault_flag_n_oe_o, 1'b1);
  endtask
  task automatic t_wdog();
    send(A_CTRL1, 9'h000);
    cyc(WDOG - 200);
    check("failsafe", failsafe_flag_n_oe_o, 1'b0);
    cyc(400);
    check("failsafe", failsafe_flag_n_oe_o, 1'b1);
    wake_reset_n_i = 1'b0;
    cyc(8);
    wake_reset_n_i = 1'b1;
    cyc(8);
    check("failsafe", failsafe_flag_n_oe_o, 1'b0);
    send(A_GLOBAL, 9'h001);
    cyc(WDOG + 400);
    check("failsafe", failsafe_flag_n_oe_o, 1'b0);
    vdd_fail_i = 1'b1;
    cyc(6);
    check("failsafe", failsafe_flag_n_oe_o, 1'b1);
    vdd_fail_i = 1'b0;
  endtask
  initial begin
    cyc(60000);
    n_mismatch++;
    conclude();
  end
  initial begin
    rst_n_i = 1'b0;
    wake_reset_n_i = 1'b0;
    direct_in_i = 2'b00;
    load_profile_sel_i = 2'b11;
    pwm_clk_i = 1'b0;
    sense_accurate_i = 1'b0;
    ov_i = 1'b0;
    uv_i = 1'b0;
    vdd_fail_i = 1'b0;
    word_ready_i = 1'b1;
    fault_a_i = '0;
    fault_b_i = '0;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(2);
    t_reset();
    t_direct();
    t_spi();
    t_fifo();
    t_fault();
    t_wdog();
    conclude();
  end
endmodule
